/* verilog/nvds_pkg.sv */
// Purpose: Shared constants and carrier types for the data/side-band pin block
// Assumes: AXI4-Lite register window with 32-bit data, byte addresses below
// Notes: Mode register bit positions follow the address bits loaded into the mode registers
`default_nettype none
package nvds_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned LANE_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE5 = 8'h04;
  localparam logic [7:0] OFF_MODE1 = 8'h08;
  localparam logic [7:0] OFF_ODT = 8'h0c;
  localparam logic [7:0] OFF_TEMP = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_BEATS = 8'h18;
  // Field positions
  localparam int unsigned CTRL_ARMED = 0;
  localparam int unsigned CTRL_CONN = 1;
  localparam int unsigned CTRL_WIDTH = 2;
  localparam int unsigned MR5_MASK = 10;
  localparam int unsigned MR5_WDBI = 11;
  localparam int unsigned MR5_RDBI = 12;
  localparam int unsigned MR1_TDQS = 11;
  // Reset values and timing
  localparam logic [7:0] TEMP_LIMIT_RST = 8'h5f;
  localparam logic [2:0] ODT_RST = 3'h0;
  localparam int unsigned ALERT_PULSE_DEF = 16;
  localparam int unsigned DBI_ZERO_LIMIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [24:0] SYNC_RST = 25'h000_0187;

  typedef enum logic [1:0] {
    NVDS_X4 = 2'b00,
    NVDS_X8 = 2'b01,
    NVDS_X16 = 2'b10
  } nvds_width_t;

  typedef enum logic [1:0] {
    NVDS_SV_IDLE = 2'b00,
    NVDS_SV_SWITCH = 2'b01,
    NVDS_SV_COPY = 2'b10,
    NVDS_SV_DONE = 2'b11
  } nvds_save_t;

  typedef struct packed {
    logic mask_en;
    logic wdbi_en;
    logic rdbi_en;
    logic nib_only;
  } nvds_lane_cfg_t;

  typedef struct packed {
    logic valid;
    logic keep;
    logic [7:0] data;
  } nvds_beat_t;
endpackage
`default_nettype wire

/* verilog/nvds_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Bits are independent levels
// Notes: Only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module nvds_sync #(
  parameter int unsigned W = 25,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } nvds_sync_st_t;
  nvds_sync_st_t s_q, s_d;

  always_comb begin
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;
endmodule // nvds_sync
`default_nettype wire

/* verilog/nvds_lane.sv */
// Purpose: One byte lane: write capture with mask/inversion, read drive with inversion
// Assumes: Strobe edge and pin bits arrive already synchronised, aligned to each other
// Notes: On writes the shared mask pin carries either the mask or the inversion flag, never both
`timescale 1ns/1ps
`default_nettype none
module nvds_lane (
  input wire logic aclk,
  input wire logic aresetn,
  input wire nvds_pkg::nvds_lane_cfg_t cfg,
  input wire logic strobe_edge,
  input wire logic [7:0] dq,
  input wire logic mask_invert_n,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  output nvds_pkg::nvds_beat_t beat,
  output logic [7:0] rd_dq,
  output logic rd_invert_n
);
  typedef struct packed {
    nvds_pkg::nvds_beat_t beat;
    logic [7:0] rd_dq;
    logic rd_inv_n;
  } nvds_lane_st_t;
  nvds_lane_st_t s_q, s_d;

  always_comb begin
    logic inv;
    inv = 1'b0;
    s_d = s_q;
    s_d.beat.valid = 1'b0;
    if (strobe_edge) begin
      s_d.beat.valid = 1'b1;
      s_d.beat.keep = !(cfg.mask_en && !mask_invert_n);
      s_d.beat.data = (cfg.wdbi_en && !mask_invert_n) ? ~dq : dq;
      if (cfg.nib_only) begin
        s_d.beat.data[7:4] = 4'h0;
      end
    end
    if (rd_valid) begin
      // Inverting when most bits are low keeps the low-driving count down
      inv = cfg.rdbi_en && ($countones(rd_byte) < (nvds_pkg::LANE_W - nvds_pkg::DBI_ZERO_LIMIT));
      s_d.rd_dq = inv ? ~rd_byte : rd_byte;
      s_d.rd_inv_n = !inv;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.rd_inv_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign beat = s_q.beat;
  assign rd_dq = s_q.rd_dq;
  assign rd_invert_n = s_q.rd_inv_n;

  a_mask_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (strobe_edge && cfg.mask_en && !mask_invert_n) |=> (beat.valid && !beat.keep))
    else $error("masked write beat was kept");

  a_read_invert: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_valid |=> (rd_dq == (rd_invert_n ? $past(rd_byte) : ~$past(rd_byte))))
    else $error("read data does not match its inversion flag");
endmodule // nvds_lane
`default_nettype wire

/* verilog/nvds_top.sv */
// Purpose: Data-side and side-band pin logic of a nonvolatile registered memory module
// Assumes: Pins and strobes are sampled by aclk; core-side signals share aclk
// Notes: Strobe pairs are oversampled, so strobe rate must stay well below aclk/4
// Operation
// - Write beats sampled with mask low are discarded.
// - Mask pin is sampled on both strobe edges; host drives it around each.
// - Mode register five bits A10..A12 choose mask or inversion on shared pin.
// - On x8, mode register one bit A11 picks mask or termination strobe.
// - Inversion flag low means data inverted, both directions.
// - Termination strobe exists only for x8 components.
// - Device drives strobe edge-aligned with reads; host centres it on writes.
// - x16: lower pair times low byte, upper pair high byte; x4/x8 one pair.
// - Strobe works only as a true/complement differential pair.
// - Write CRC error pulls alert low for a fixed pulse, then releases.
// - Parity error holds alert low until internal recovery ends.
// - In connectivity test the alert pin is an input.
// - Thermal event output goes low above the critical threshold.
// - Forced-backup low switches muxes from host and copies DRAM to flash.
// - Termination strobe pair gets the same termination as the data strobe.
// - Termination strobe off: true pin masks, complement pin unused.
// - Write mask exists only for x8 and x16.
// - While armed, the host reset pin is ignored.
`timescale 1ns/1ps
`default_nettype none
module nvds_top #(
  parameter int unsigned ALERT_PULSE = nvds_pkg::ALERT_PULSE_DEF,
  parameter int unsigned COPY_AW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] dq_sense,
  output logic [15:0] dq_drive,
  output logic dq_oe,
  input wire logic [1:0] mask_invert_n_sense,
  output logic [1:0] mask_invert_n_drive,
  output logic mask_invert_n_oe,
  input wire logic lower_strobe_true_sense,
  input wire logic lower_strobe_comp_sense,
  input wire logic upper_strobe_true_sense,
  input wire logic upper_strobe_comp_sense,
  output logic lower_strobe_true_drive,
  output logic lower_strobe_comp_drive,
  output logic upper_strobe_true_drive,
  output logic upper_strobe_comp_drive,
  output logic strobe_oe,
  output logic [2:0] strobe_odt,
  output logic [2:0] term_strobe_odt,
  output logic term_strobe_comp_oe,
  input wire logic alert_n_sense,
  output logic alert_n_drive,
  output logic alert_n_oe,
  output logic event_n,
  input wire logic save_n,
  input wire logic host_reset_n,
  input wire logic crc_err,
  input wire logic parity_err,
  input wire logic recovery_done,
  input wire logic [7:0] temp,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic wr_valid,
  output logic [15:0] wr_data,
  output logic [1:0] wr_keep,
  output logic host_mux,
  output logic copy_valid,
  output logic [COPY_AW-1:0] copy_addr,
  input wire logic copy_ready,
  output logic save_done
);
  localparam logic [15:0] PULSE_LEN = 16'(ALERT_PULSE);
  localparam logic [COPY_AW-1:0] COPY_LAST = '1;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic armed;
    logic conn;
    nvds_pkg::nvds_width_t width;
    logic [2:0] mr5;
    logic mr1_tdqs;
    logic [2:0] odt;
    logic [7:0] temp_limit;
    logic [15:0] crc_cnt;
    logic par_hold;
    logic alert_oe;
    logic alert_lvl;
    logic alert_seen;
    logic event_n;
    nvds_pkg::nvds_save_t save;
    logic save_last;
    logic host_mux;
    logic copy_valid;
    logic [COPY_AW-1:0] copy_addr;
    logic save_done;
    logic [1:0] last_lvl;
    logic rd_oe;
    logic strobe_lvl;
    logic strobe_cmp;
    logic wr_valid;
    logic [15:0] wr_data;
    logic [1:0] wr_keep;
    logic [15:0] beats;
    logic [2:0] strobe_odt;
    logic [2:0] term_odt;
  } nvds_top_st_t;
  nvds_top_st_t s_q, s_d;

  logic [24:0] pins_q;
  logic [15:0] dq_s;
  logic [1:0] mask_s;
  logic [1:0] st_t;
  logic [1:0] st_c;
  logic save_s, alert_s, hrst_s;
  logic [1:0] lane_edge;
  logic tdqs_act, wr_fire;
  nvds_pkg::nvds_lane_cfg_t cfg0, cfg1;
  nvds_pkg::nvds_beat_t beat0, beat1;
  logic [7:0] rd_dq0, rd_dq1;
  logic inv0_n, inv1_n;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling and strobe edges
  nvds_sync #(.W(25), .RST_VAL(nvds_pkg::SYNC_RST)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({dq_sense, mask_invert_n_sense, upper_strobe_true_sense, lower_strobe_true_sense,
           upper_strobe_comp_sense, lower_strobe_comp_sense, save_n, alert_n_sense, host_reset_n}),
    .q(pins_q)
  );
  assign dq_s = pins_q[24:9];
  assign mask_s = pins_q[8:7];
  assign st_t = pins_q[6:5];
  assign st_c = pins_q[4:3];
  assign save_s = pins_q[2];
  assign alert_s = pins_q[1];
  assign hrst_s = pins_q[0];

  // A pair with both legs equal is no valid strobe state and is not an edge
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lane_edge[i] = !s_q.rd_oe && (st_t[i] ^ st_c[i]) && (st_t[i] != s_q.last_lvl[i]);
    end
    lane_edge[1] = lane_edge[1] && (s_q.width == nvds_pkg::NVDS_X16);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared pin function select
  assign tdqs_act = s_q.mr1_tdqs && (s_q.width == nvds_pkg::NVDS_X8);
  always_comb begin
    cfg0.mask_en = s_q.mr5[0] && !tdqs_act && (s_q.width != nvds_pkg::NVDS_X4);
    cfg0.wdbi_en = s_q.mr5[1] && !cfg0.mask_en && !tdqs_act && (s_q.width != nvds_pkg::NVDS_X4);
    cfg0.rdbi_en = s_q.mr5[2] && !tdqs_act && (s_q.width != nvds_pkg::NVDS_X4);
    cfg0.nib_only = (s_q.width == nvds_pkg::NVDS_X4);
    cfg1 = cfg0;
    cfg1.nib_only = 1'b0;
  end

  nvds_lane u_lane0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg0),
    .strobe_edge(lane_edge[0]),
    .dq(dq_s[7:0]),
    .mask_invert_n(mask_s[0]),
    .rd_valid(rd_valid),
    .rd_byte(rd_data[7:0]),
    .beat(beat0),
    .rd_dq(rd_dq0),
    .rd_invert_n(inv0_n)
  );
  nvds_lane u_lane1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg1),
    .strobe_edge(lane_edge[1]),
    .dq(dq_s[15:8]),
    .mask_invert_n(mask_s[1]),
    .rd_valid(rd_valid),
    .rd_byte(rd_data[15:8]),
    .beat(beat1),
    .rd_dq(rd_dq1),
    .rd_invert_n(inv1_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;

  always_comb begin
    s_d = s_q;
    // Register bus
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awready = 1'b0;
      s_d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wready = 1'b0;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = nvds_pkg::RESP_OKAY;
      case (s_q.waddr)
        nvds_pkg::OFF_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.armed = s_q.wdata[nvds_pkg::CTRL_ARMED];
            s_d.conn = s_q.wdata[nvds_pkg::CTRL_CONN];
            s_d.width = nvds_pkg::nvds_width_t'(s_q.wdata[nvds_pkg::CTRL_WIDTH +: 2]);
          end
        end
        nvds_pkg::OFF_MODE5: if (s_q.wstrb[1]) s_d.mr5 = s_q.wdata[nvds_pkg::MR5_MASK +: 3];
        nvds_pkg::OFF_MODE1: if (s_q.wstrb[1]) s_d.mr1_tdqs = s_q.wdata[nvds_pkg::MR1_TDQS];
        nvds_pkg::OFF_ODT: if (s_q.wstrb[0]) s_d.odt = s_q.wdata[2:0];
        nvds_pkg::OFF_TEMP: if (s_q.wstrb[0]) s_d.temp_limit = s_q.wdata[7:0];
        nvds_pkg::OFF_STATUS, nvds_pkg::OFF_BEATS: begin
        end
        default: s_d.bresp = nvds_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = nvds_pkg::RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        nvds_pkg::OFF_CTRL: s_d.rdata[3:0] = {s_q.width, s_q.conn, s_q.armed};
        nvds_pkg::OFF_MODE5: s_d.rdata[nvds_pkg::MR5_MASK +: 3] = s_q.mr5;
        nvds_pkg::OFF_MODE1: s_d.rdata[nvds_pkg::MR1_TDQS] = s_q.mr1_tdqs;
        nvds_pkg::OFF_ODT: s_d.rdata[2:0] = s_q.odt;
        nvds_pkg::OFF_TEMP: s_d.rdata[7:0] = s_q.temp_limit;
        nvds_pkg::OFF_STATUS: begin
          s_d.rdata[7:0] = {tdqs_act, s_q.save, s_q.save_done, s_q.event_n, s_q.alert_seen, s_q.par_hold,
                            s_q.alert_oe};
          s_d.rdata[15:8] = temp;
        end
        nvds_pkg::OFF_BEATS: s_d.rdata[15:0] = s_q.beats;
        default: s_d.rresp = nvds_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    // Host reset pin clears the mode settings unless the save path is armed
    if (!hrst_s && !s_q.armed) begin
      s_d.mr5 = 3'h0;
      s_d.mr1_tdqs = 1'b0;
    end
    // Alert: driven low, outside connectivity test, while either the CRC pulse count runs or the parity hold is set
    if (s_q.crc_cnt != 16'h0000) begin
      s_d.crc_cnt = s_q.crc_cnt - 16'h0001;
    end else if (crc_err) begin
      s_d.crc_cnt = PULSE_LEN;
    end
    if (parity_err) begin
      s_d.par_hold = 1'b1;
    end else if (recovery_done) begin
      s_d.par_hold = 1'b0;
    end
    s_d.alert_oe = !s_d.conn && (s_d.par_hold || s_d.crc_cnt != 16'h0000);
    s_d.alert_lvl = !s_d.alert_oe;
    if (s_q.conn) begin
      s_d.alert_seen = !alert_s;
    end
    s_d.event_n = !(temp > s_q.temp_limit);
    // Forced save
    s_d.save_last = save_s;
    case (s_q.save)
      nvds_pkg::NVDS_SV_IDLE: begin
        if (s_q.save_last && !save_s) begin
          s_d.host_mux = 1'b0;
          s_d.save_done = 1'b0;
          s_d.save = nvds_pkg::NVDS_SV_SWITCH;
        end
      end
      nvds_pkg::NVDS_SV_SWITCH: begin
        s_d.copy_valid = 1'b1;
        s_d.copy_addr = '0;
        s_d.save = nvds_pkg::NVDS_SV_COPY;
      end
      nvds_pkg::NVDS_SV_COPY: begin
        if (copy_ready) begin
          if (s_q.copy_addr == COPY_LAST) begin
            s_d.copy_valid = 1'b0;
            s_d.save_done = 1'b1;
            s_d.save = nvds_pkg::NVDS_SV_DONE;
          end else begin
            s_d.copy_addr = s_q.copy_addr + 1'b1;
          end
        end
      end
      nvds_pkg::NVDS_SV_DONE: begin
        if (save_s) begin
          s_d.host_mux = 1'b1;
          s_d.save = nvds_pkg::NVDS_SV_IDLE;
        end
      end
      default: s_d.save = nvds_pkg::NVDS_SV_IDLE;
    endcase
    // Strobes: read strobe toggles in the same edge as the lane data
    for (int i = 0; i < 2; i++) begin
      if (st_t[i] ^ st_c[i]) begin
        s_d.last_lvl[i] = st_t[i];
      end
    end
    s_d.rd_oe = rd_valid;
    if (rd_valid) begin
      s_d.strobe_lvl = !s_q.strobe_lvl;
      s_d.strobe_cmp = s_q.strobe_lvl;
    end
    s_d.wr_valid = beat0.valid || beat1.valid;
    s_d.wr_data = {beat1.data, beat0.data};
    s_d.wr_keep = {beat1.valid && beat1.keep, beat0.valid && beat0.keep};
    if (s_d.wr_keep != 2'b00) begin
      s_d.beats = s_q.beats + 16'h0001;
    end
    s_d.strobe_odt = s_q.odt;
    s_d.term_odt = tdqs_act ? s_q.odt : 3'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.width <= nvds_pkg::NVDS_X8;
      s_q.temp_limit <= nvds_pkg::TEMP_LIMIT_RST;
      s_q.odt <= nvds_pkg::ODT_RST;
      s_q.alert_lvl <= 1'b1;
      s_q.event_n <= 1'b1;
      s_q.save_last <= 1'b1;
      s_q.host_mux <= 1'b1;
      s_q.strobe_cmp <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign dq_drive = {rd_dq1, rd_dq0};
  assign dq_oe = s_q.rd_oe;
  assign mask_invert_n_drive = {inv1_n, inv0_n};
  assign mask_invert_n_oe = s_q.rd_oe && s_q.mr5[2] && !tdqs_act;
  assign lower_strobe_true_drive = s_q.strobe_lvl;
  assign upper_strobe_true_drive = s_q.strobe_lvl;
  assign lower_strobe_comp_drive = s_q.strobe_cmp;
  assign upper_strobe_comp_drive = s_q.strobe_cmp;
  assign strobe_oe = s_q.rd_oe;
  assign strobe_odt = s_q.strobe_odt;
  assign term_strobe_odt = s_q.term_odt;
  // The complement termination pin is never driven; it only terminates
  assign term_strobe_comp_oe = s_q.copy_valid && 1'b0;
  assign alert_n_drive = s_q.alert_lvl;
  assign alert_n_oe = s_q.alert_oe;
  assign event_n = s_q.event_n;
  assign host_mux = s_q.host_mux;
  assign copy_valid = s_q.copy_valid;
  assign copy_addr = s_q.copy_addr;
  assign save_done = s_q.save_done;
  assign wr_valid = s_q.wr_valid;
  assign wr_data = s_q.wr_data;
  assign wr_keep = s_q.wr_keep;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking nvds_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_crc_alert_low: assert property (
    (crc_err && s_q.crc_cnt == 16'h0000 && !s_q.conn && !wr_fire) |=> (alert_n_oe && !alert_n_drive))
    else $error("crc error did not pull alert low");
  a_crc_alert_end: assert property (
    (s_q.crc_cnt == 16'h0001 && !s_q.par_hold && !parity_err && !crc_err) |=> !alert_n_oe)
    else $error("crc alert pulse did not end");
  a_parity_hold: assert property (
    (s_q.par_hold && !recovery_done && !s_q.conn && !wr_fire) |=> alert_n_oe)
    else $error("parity alert released before recovery");
  a_conn_input: assert property (
    (s_q.conn && $past(s_q.conn)) |-> !alert_n_oe)
    else $error("alert driven in connectivity test");
  a_event_hot: assert property (
    (temp > s_q.temp_limit) |=> !event_n)
    else $error("thermal event not raised");
  a_save_switch: assert property (
    (s_q.save == nvds_pkg::NVDS_SV_IDLE && s_q.save_last && !save_s) |=> (!host_mux ##1 copy_valid))
    else $error("forced save did not switch and start copy");
  a_term_x8: assert property (
    (term_strobe_odt != 3'h0) |-> $past(s_q.width == nvds_pkg::NVDS_X8 && s_q.mr1_tdqs))
    else $error("termination strobe active outside x8");
  a_x4_nomask: assert property (
    (s_q.width == nvds_pkg::NVDS_X4) |-> !cfg0.mask_en)
    else $error("mask enabled on x4");
  a_reset_blocked: assert property (
    (s_q.armed && !hrst_s && !wr_fire) |=> $stable(s_q.mr5))
    else $error("host reset disturbed settings while armed");
endmodule // nvds_top
`default_nettype wire

/* bench/nvds_host.sv */
// Purpose: Host controller model that drives write bursts on the strobe pairs
// Assumes: Strobe idles true low and comp high between bursts
// Notes: After each beat the data and mask lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module nvds_host (
  output logic [15:0] dq,
  output logic [1:0] mask_n,
  output logic stb_t,
  output logic stb_c
);
  initial begin
    dq = 16'h0000;
    mask_n = 2'b11;
    {stb_t, stb_c} = 2'b01;
  end
  // One strobe edge per beat; send beats in pairs so the strobe ends idle
  task automatic beat(input logic [15:0] d, input logic [1:0] m);
    dq <= d;
    mask_n <= m;
    #40 {stb_t, stb_c} <= {~stb_t, stb_t};
    #20 dq <= ~d;
    mask_n <= ~m;
    #20;
  endtask
endmodule // nvds_host
`default_nettype wire

/* bench/nvds_top_tb.sv */
// Purpose: Self-checking bench for the data and side-band pin block
// Assumes: Alert pulse shortened to 4 cycles, copy port always ready
// Notes: Write beats are compared by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module nvds_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, crc_err = 1'b0, parity_err = 1'b0, recovery_done = 1'b0;
  logic rd_valid = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dq_oe;
  logic alert_n_drive, event_n, wr_valid, st, sc, host_mux, save_done, copy_valid;
  logic save_n = 1'b1, host_reset_n = 1'b1;
  logic [2:0] copy_addr, strobe_odt, term_strobe_odt;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, temp = 8'h20;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [15:0] rd_data = 16'h0000, dq, dq_drive, wr_data, d;
  logic [1:0] s_axi_rresp, s_axi_bresp, mask_n, mask_invert_n_drive, wr_keep;
  logic [17:0] exp_q[$];
  integer seed = 32'h9204;
  int n_fail = 0, n_tests = 0;
  always #2.5 aclk = ~aclk;
  nvds_host nvds_host_inst (.dq(dq), .mask_n(mask_n), .stb_t(st), .stb_c(sc));
  nvds_top #(.ALERT_PULSE(4), .COPY_AW(3)) nvds_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dq_sense(dq), .dq_drive, .dq_oe, .mask_invert_n_sense(mask_n),
    .mask_invert_n_drive, .mask_invert_n_oe(), .lower_strobe_true_sense(st), .lower_strobe_comp_sense(sc),
    .upper_strobe_true_sense(st), .upper_strobe_comp_sense(sc), .lower_strobe_true_drive(),
    .lower_strobe_comp_drive(), .upper_strobe_true_drive(), .upper_strobe_comp_drive(), .strobe_oe(),
    .strobe_odt, .term_strobe_odt, .term_strobe_comp_oe(), .alert_n_sense(1'b1), .alert_n_drive,
    .alert_n_oe(), .event_n, .save_n, .host_reset_n, .crc_err, .parity_err, .recovery_done,
    .temp, .rd_valid, .rd_data, .wr_valid, .wr_data, .wr_keep, .host_mux, .copy_valid, .copy_addr,
    .copy_ready(1'b1), .save_done);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, nvds_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, e);
  endtask
  // Masked bytes carry no defined data, so only kept bytes are compared
  task automatic beat(input logic [1:0] k, input logic [15:0] x, input logic [1:0] m);
    exp_q.push_back({k, x & {{8{k[1]}}, {8{k[0]}}}});
    nvds_host_inst.beat(d, m);
  endtask
  always @(posedge aclk) begin
    logic [17:0] e;
    if (wr_valid === 1'b1) begin
      e = exp_q.pop_front();
      chk({wr_keep, wr_data & {{8{e[17]}}, {8{e[16]}}}}, e);
    end
  end
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(nvds_pkg::OFF_TEMP, 34'h0_0000_005f);
    rd(8'h40, 34'h2_0000_0000);
    wr(nvds_pkg::OFF_CTRL, 32'h0000_0008);
    wr(nvds_pkg::OFF_MODE5, 32'h0000_0400);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      beat(i[1:0], d, i[1:0]);
    end
    wr(nvds_pkg::OFF_MODE5, 32'h0000_0800);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      beat(2'b11, d ^ {{8{~i[1]}}, {8{~i[0]}}}, i[1:0]);
    end
    wr(nvds_pkg::OFF_MODE5, 32'h0000_1000);
    @(posedge aclk);
    rd_data <= {d[15:8] | 8'hf0, d[7:0] & 8'h07};
    rd_valid <= 1'b1;
    @(posedge aclk);
    rd_valid <= 1'b0;
    @(posedge aclk);
    chk({dq_oe, mask_invert_n_drive, dq_drive}, {1'b1, 2'b10, d[15:8] | 8'hf0, ~(d[7:0] & 8'h07)});
    wr(nvds_pkg::OFF_CTRL, 32'h0000_0000);
    wr(nvds_pkg::OFF_MODE5, 32'h0000_0400);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      beat(2'b01, d & 16'h000f, 2'b00);
    end
    @(posedge aclk);
    crc_err <= 1'b1;
    @(posedge aclk);
    crc_err <= 1'b0;
    for (int i = 0; i <= 4; i++) begin
      @(posedge aclk);
      chk(alert_n_drive, i == 4);
    end
    parity_err <= 1'b1;
    @(posedge aclk);
    parity_err <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(alert_n_drive, 1'b0);
    recovery_done <= 1'b1;
    @(posedge aclk);
    recovery_done <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(alert_n_drive, 1'b1);
    temp <= 8'h60;
    repeat (3) @(posedge aclk);
    chk(event_n, 1'b0);
    temp <= 8'h5f;
    repeat (3) @(posedge aclk);
    chk(event_n, 1'b1);
    wr(nvds_pkg::OFF_CTRL, 32'h0000_0004);
    wr(nvds_pkg::OFF_MODE1, 32'h0000_0800);
    wr(nvds_pkg::OFF_ODT, 32'h0000_0005);
    @(posedge aclk);
    chk({term_strobe_odt, strobe_odt}, 6'h2d);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      beat(2'b01, d, 2'b00);
    end
    host_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    host_reset_n <= 1'b1;
    rd(nvds_pkg::OFF_MODE5, 34'h0_0000_0000);
    chk(term_strobe_odt, 3'h0);
    wr(nvds_pkg::OFF_CTRL, 32'h0000_0005);
    wr(nvds_pkg::OFF_MODE5, 32'h0000_0400);
    host_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    host_reset_n <= 1'b1;
    rd(nvds_pkg::OFF_MODE5, 34'h0_0000_0400);
    // Memory is taken to be in self refresh before the save is forced
    save_n <= 1'b0;
    repeat (20) @(posedge aclk);
    chk({host_mux, save_done, copy_valid, copy_addr}, 6'h17);
    save_n <= 1'b1;
    repeat (5) @(posedge aclk);
    chk({host_mux, save_done, copy_valid, copy_addr}, 6'h37);
    repeat (20) @(posedge aclk);
    report_and_stop();
  end
endmodule // nvds_top_tb
`default_nettype wire
